//--- rtl/psc_pkg.sv
package psc_pkg;

  // register indices on the model-specific register port
  localparam logic [11:0] PSC_ADR_GLOB_STATUS   = 12'h38E;
  localparam logic [11:0] PSC_ADR_GLOB_ENABLE   = 12'h38F;
  localparam logic [11:0] PSC_ADR_GLOB_OVF_CLR  = 12'h390;
  localparam logic [11:0] PSC_ADR_SAMPLE_ENABLE = 12'h3F1;
  localparam logic [11:0] PSC_ADR_CAPABILITY    = 12'h3E0;
  localparam logic [11:0] PSC_ADR_EVSEL0        = 12'h200;
  localparam logic [11:0] PSC_ADR_COUNTER0      = 12'h201;
  localparam logic [11:0] PSC_ADR_BUF_BASE      = 12'h202;
  localparam logic [11:0] PSC_ADR_BUF_INDEX     = 12'h203;
  localparam logic [11:0] PSC_ADR_BUF_MAX       = 12'h204;
  localparam logic [11:0] PSC_ADR_CTR_RELOAD    = 12'h205;
  localparam logic [11:0] PSC_ADR_DEBUG_CTRL    = 12'h206;

  // field positions
  localparam int PSC_BIT_CTR0        = 0;
  localparam int PSC_BIT_BUF_FULL    = 62;
  localparam int PSC_BIT_SMP_EN      = 0;
  localparam int PSC_BIT_TRAP        = 6;
  localparam int PSC_BIT_SAVE_ARCH   = 7;
  localparam int PSC_BIT_LAYOUT_LO   = 8;
  localparam int PSC_BIT_LAYOUT_HI   = 11;
  localparam int PSC_BIT_EV_USR      = 16;
  localparam int PSC_BIT_EV_OS       = 17;
  localparam int PSC_BIT_EV_INT      = 20;
  localparam int PSC_BIT_EV_EN       = 22;
  localparam int PSC_BIT_FREEZE      = 0;

  // record layout
  localparam logic [3:0]  PSC_LAYOUT_CODE    = 4'h0;
  localparam int          PSC_REC_WORDS      = 10;
  localparam logic [63:0] PSC_REC_BYTES      = 64'h0000_0000_0000_0050;
  localparam logic [63:0] PSC_ZERO64         = 64'h0000_0000_0000_0000;

  typedef enum logic [2:0] {
    PSC_IDLE,
    PSC_ARMED,
    PSC_NEXT,
    PSC_STORE,
    PSC_BTS,
    PSC_IRQ
  } psc_state_t;

  // event codes that may drive a precise capture
  function automatic logic psc_is_precise(input logic [7:0] sel, input logic [7:0] qual);
    case (sel)
      8'hC0:   psc_is_precise = (qual == 8'h00);
      8'hC1:   psc_is_precise = (qual == 8'hFE);
      8'hC5:   psc_is_precise = (qual == 8'h00);
      8'hC7:   psc_is_precise = (qual == 8'h1F);
      8'hCB:   psc_is_precise = (qual == 8'h01) || (qual == 8'h02) || (qual == 8'h04)
                                || (qual == 8'h08) || (qual == 8'h10);
      default: psc_is_precise = 1'b0;
    endcase
  endfunction

endpackage

//--- rtl/psc_store_seq.sv
`timescale 1ns/1ns
`default_nettype none
module psc_store_seq
  import psc_pkg::*;
#(
  parameter int WORDS = PSC_REC_WORDS
)
(
  input  wire logic               clk,
  input  wire logic               rst,
  input  wire logic               start,
  input  wire logic [63:0]        base,
  input  wire logic [WORDS*64-1:0] record,
  output logic                    st_valid,
  output logic [63:0]             st_addr,
  output logic [63:0]             st_data,
  input  wire logic               st_ready,
  output logic                    busy,
  output logic                    done
);

  logic [WORDS*64-1:0] rec_reg;
  logic [63:0]         addr_reg;
  logic [7:0]          idx_reg;

  // the record and its address are latched at start so a later reconfiguration
  // cannot redirect entries already in flight
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      busy     <= 1'b0;
      done     <= 1'b0;
      idx_reg  <= 8'h00;
      rec_reg  <= '0;
      addr_reg <= PSC_ZERO64;
    end
    else
    begin
      done <= 1'b0;
      if (start && !busy)
      begin
        busy     <= 1'b1;
        rec_reg  <= record;
        addr_reg <= base;
        idx_reg  <= 8'h00;
      end
      else if (busy && st_valid && st_ready)
      begin
        addr_reg <= addr_reg + 64'h0000_0000_0000_0008;
        rec_reg  <= rec_reg >> 64;
        idx_reg  <= idx_reg + 8'h01;
        if (idx_reg == 8'(WORDS - 1))
        begin
          busy <= 1'b0;
          done <= 1'b1;
        end
      end
    end
  end

  assign st_valid = busy;
  assign st_addr  = addr_reg;
  assign st_data  = rec_reg[63:0];

  a_entry_hold: assert property (@(posedge clk) disable iff (rst)
    st_valid && !st_ready |=> st_valid && $stable(st_addr) && $stable(st_data))
    else $error("store entry changed while stalled");

endmodule
`default_nettype wire

//--- rtl/psc_ctrl.sv
// What this block does
// - a precise record completes before the branch trace record is processed
// - overflow interrupt waits until precise and branch trace records are done
// - only general counter zero may arm or produce a precise record
// - bit 0 of precise_sampling_enable turns sampling on or off
// - records are built from 64-bit entries written to memory
// - capability bit 6: 1 capture after next instruction, 0 before it
// - capability bit 7, save architectural state, always reads one
// - capability bits 11:8 read 0000: registers, pointer and flags only
// - record holds state of the instruction after the sampled one
// - only listed precise-capable event codes trigger a capture
// - counter overflow sources share one interrupt request output; buffer full only sets its status bit
// - freeze_on_interrupt clears counter enables when the interrupt fires
// - overflow recorded in status, cleared by writing the clear register
// - a record in flight finishes at its original buffer address
// - overflow of a sampling counter arms; next qualifying event captures
// - bounds check passes: store, clear overflow, reload; fails: skip
// - global enable ANDed with privilege enables gates counting
`timescale 1ns/1ns
`default_nettype none
module psc_ctrl
  import psc_pkg::*;
#(
  parameter int         CTR_WIDTH  = 40,
  parameter logic       TRAP_LIKE  = 1'b1
)
(
  input  wire logic          clk,
  input  wire logic          rst,
  input  wire logic          msr_wr,
  input  wire logic          msr_rd,
  input  wire logic [11:0]   msr_addr,
  input  wire logic [63:0]   msr_wdata,
  output logic [63:0]        msr_rdata,
  output logic               msr_rd_valid,
  input  wire logic          evt_valid,
  input  wire logic [7:0]    evt_select,
  input  wire logic [7:0]    evt_qual,
  input  wire logic          evt_ring0,
  input  wire logic          insn_retire,
  input  wire logic [63:0]   core_flags,
  input  wire logic [63:0]   core_ip,
  input  wire logic [511:0]  core_gprs,
  input  wire logic          branch_trace_req,
  output logic               branch_trace_go,
  input  wire logic          branch_trace_done,
  output logic               overflow_interrupt_request,
  output logic               st_valid,
  output logic [63:0]        st_addr,
  output logic [63:0]        st_data,
  input  wire logic          st_ready
);

  ////////////////////////////////////////////////////////////////////////////////
  // registers

  logic [63:0]          glob_enable_reg;
  logic [63:0]          glob_status_reg;
  logic [63:0]          smp_enable_reg;
  logic [63:0]          evsel_reg;
  logic [CTR_WIDTH-1:0] counter_reg;
  logic [63:0]          buf_base_reg;
  logic [63:0]          buf_index_reg;
  logic [63:0]          buf_max_reg;
  logic [CTR_WIDTH-1:0] reload_reg;
  logic [63:0]          debug_ctrl_reg;
  logic [63:0]          capability;
  psc_state_t           state_reg;
  logic                 bts_pend_reg;
  logic                 plain_irq_reg;
  logic [64*PSC_REC_WORDS-1:0] record_reg;
  logic                 seq_start_reg;
  logic                 seq_busy;
  logic                 seq_done;

  logic wr_evsel;
  logic wr_ctr;
  logic wr_clr;
  logic evt_match;
  logic count_en;
  logic ctr_ovf;
  logic smp_on;
  logic trigger;
  logic bounds_ok;
  logic store_ok;
  logic irq_fire;

  assign wr_evsel = msr_wr && (msr_addr == PSC_ADR_EVSEL0);
  assign wr_ctr   = msr_wr && (msr_addr == PSC_ADR_COUNTER0);
  assign wr_clr   = msr_wr && (msr_addr == PSC_ADR_GLOB_OVF_CLR);

  always_comb
  begin
    capability = PSC_ZERO64;
    capability[PSC_BIT_TRAP] = TRAP_LIKE;
    capability[PSC_BIT_SAVE_ARCH] = 1'b1;
    capability[PSC_BIT_LAYOUT_HI:PSC_BIT_LAYOUT_LO] = PSC_LAYOUT_CODE;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // counting

  assign evt_match = evt_valid && (evt_select == evsel_reg[7:0])
                     && (evt_qual == evsel_reg[15:8]);
  assign count_en  = glob_enable_reg[PSC_BIT_CTR0] && evsel_reg[PSC_BIT_EV_EN]
                     && ((evt_ring0 && evsel_reg[PSC_BIT_EV_OS])
                         || (!evt_ring0 && evsel_reg[PSC_BIT_EV_USR]));
  assign ctr_ovf   = count_en && evt_match && (&counter_reg);
  assign smp_on    = smp_enable_reg[PSC_BIT_SMP_EN];
  assign trigger   = (state_reg == PSC_ARMED) && count_en && evt_match
                     && psc_is_precise(evt_select, evt_qual);
  assign bounds_ok = (buf_index_reg + PSC_REC_BYTES) <= buf_max_reg;
  assign store_ok  = (state_reg == PSC_STORE) && seq_done;

  always_ff @(posedge clk)
  begin
    if (rst)
      counter_reg <= '0;
    else if (wr_ctr)
      counter_reg <= msr_wdata[CTR_WIDTH-1:0];
    else if (store_ok)
      counter_reg <= reload_reg;
    else if (count_en && evt_match)
      counter_reg <= counter_reg + CTR_WIDTH'(1);
  end

  ////////////////////////////////////////////////////////////////////////////////
  // software-written control registers

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      smp_enable_reg <= PSC_ZERO64;
      evsel_reg      <= PSC_ZERO64;
      buf_base_reg   <= PSC_ZERO64;
      buf_max_reg    <= PSC_ZERO64;
      reload_reg     <= '0;
      debug_ctrl_reg <= PSC_ZERO64;
    end
    else if (msr_wr)
    begin
      case (msr_addr)
        PSC_ADR_SAMPLE_ENABLE: smp_enable_reg <= {63'h0, msr_wdata[PSC_BIT_SMP_EN]};
        PSC_ADR_EVSEL0:        evsel_reg      <= msr_wdata;
        PSC_ADR_BUF_BASE:      buf_base_reg   <= msr_wdata;
        PSC_ADR_BUF_MAX:       buf_max_reg    <= msr_wdata;
        PSC_ADR_CTR_RELOAD:    reload_reg     <= msr_wdata[CTR_WIDTH-1:0];
        PSC_ADR_DEBUG_CTRL:    debug_ctrl_reg <= {63'h0, msr_wdata[PSC_BIT_FREEZE]};
        default:               ;
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      glob_enable_reg <= PSC_ZERO64;
    else if (irq_fire && debug_ctrl_reg[PSC_BIT_FREEZE])
      glob_enable_reg <= PSC_ZERO64;
    else if (msr_wr && (msr_addr == PSC_ADR_GLOB_ENABLE))
      glob_enable_reg <= msr_wdata;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      buf_index_reg <= PSC_ZERO64;
    else if (store_ok)
      buf_index_reg <= buf_index_reg + PSC_REC_BYTES;
    else if (msr_wr && (msr_addr == PSC_ADR_BUF_INDEX))
      buf_index_reg <= msr_wdata;
  end

  // status: hardware sets win over a software clear in the same cycle
  always_ff @(posedge clk)
  begin
    if (rst)
      glob_status_reg <= PSC_ZERO64;
    else
    begin
      if (wr_clr)
        glob_status_reg <= glob_status_reg & ~msr_wdata;
      if (store_ok)
        glob_status_reg[PSC_BIT_CTR0] <= 1'b0;
      if (ctr_ovf)
        glob_status_reg[PSC_BIT_CTR0] <= 1'b1;
      if (trigger && !bounds_ok)
        glob_status_reg[PSC_BIT_BUF_FULL] <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // capture sequence

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      state_reg     <= PSC_IDLE;
      seq_start_reg <= 1'b0;
      record_reg    <= '0;
    end
    else
    begin
      seq_start_reg <= 1'b0;
      case (state_reg)
        PSC_IDLE:
          if (ctr_ovf && smp_on && !plain_irq_reg)
            state_reg <= PSC_ARMED;
        PSC_ARMED:
          if (!smp_on)
            state_reg <= PSC_IDLE;
          else if (trigger && !bounds_ok)
            state_reg <= PSC_IDLE;
          else if (trigger && TRAP_LIKE)
            state_reg <= PSC_NEXT;
          else if (trigger)
          begin
            record_reg    <= {core_gprs, core_ip, core_flags};
            seq_start_reg <= 1'b1;
            state_reg     <= PSC_STORE;
          end
        PSC_NEXT:
          if (insn_retire)
          begin
            record_reg    <= {core_gprs, core_ip, core_flags};
            seq_start_reg <= 1'b1;
            state_reg     <= PSC_STORE;
          end
        PSC_STORE:
          if (seq_done)
            state_reg <= bts_pend_reg ? PSC_BTS : PSC_IRQ;
        PSC_BTS:
          if (branch_trace_done)
            state_reg <= PSC_IRQ;
        PSC_IRQ:
          state_reg <= PSC_IDLE;
        default:
          state_reg <= PSC_IDLE;
      endcase
    end
  end

  // branch trace request seen alongside the sampled instruction is deferred
  always_ff @(posedge clk)
  begin
    if (rst)
      bts_pend_reg <= 1'b0;
    else if (state_reg == PSC_IDLE)
      bts_pend_reg <= 1'b0;
    else if (branch_trace_req && (state_reg != PSC_BTS))
      bts_pend_reg <= 1'b1;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      branch_trace_go <= 1'b0;
    else
      branch_trace_go <= (state_reg == PSC_STORE) && seq_done && bts_pend_reg;
  end

  // non-precise overflow with its own interrupt enable
  always_ff @(posedge clk)
  begin
    if (rst)
      plain_irq_reg <= 1'b0;
    else if (ctr_ovf && !smp_on && evsel_reg[PSC_BIT_EV_INT])
      plain_irq_reg <= 1'b1;
    else if (irq_fire)
      plain_irq_reg <= 1'b0;
  end

  assign irq_fire = (state_reg == PSC_IRQ) || (plain_irq_reg && (state_reg == PSC_IDLE));

  always_ff @(posedge clk)
  begin
    if (rst)
      overflow_interrupt_request <= 1'b0;
    else
      overflow_interrupt_request <= irq_fire;
  end

  psc_store_seq #(
    .WORDS    (PSC_REC_WORDS)
  ) u_store (
    .clk      (clk),
    .rst      (rst),
    .start    (seq_start_reg),
    .base     (buf_base_reg + buf_index_reg),
    .record   (record_reg),
    .st_valid (st_valid),
    .st_addr  (st_addr),
    .st_data  (st_data),
    .st_ready (st_ready),
    .busy     (seq_busy),
    .done     (seq_done)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // register reads

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      msr_rdata    <= PSC_ZERO64;
      msr_rd_valid <= 1'b0;
    end
    else
    begin
      msr_rd_valid <= msr_rd;
      if (msr_rd)
      begin
        case (msr_addr)
          PSC_ADR_GLOB_STATUS:   msr_rdata <= glob_status_reg;
          PSC_ADR_GLOB_ENABLE:   msr_rdata <= glob_enable_reg;
          PSC_ADR_SAMPLE_ENABLE: msr_rdata <= smp_enable_reg;
          PSC_ADR_CAPABILITY:    msr_rdata <= capability;
          PSC_ADR_EVSEL0:        msr_rdata <= evsel_reg;
          PSC_ADR_COUNTER0:      msr_rdata <= 64'(counter_reg);
          PSC_ADR_BUF_BASE:      msr_rdata <= buf_base_reg;
          PSC_ADR_BUF_INDEX:     msr_rdata <= buf_index_reg;
          PSC_ADR_BUF_MAX:       msr_rdata <= buf_max_reg;
          PSC_ADR_CTR_RELOAD:    msr_rdata <= 64'(reload_reg);
          PSC_ADR_DEBUG_CTRL:    msr_rdata <= debug_ctrl_reg;
          default:               msr_rdata <= PSC_ZERO64;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // checks

  sequence s_store_end;
    (state_reg == PSC_STORE) && seq_done;
  endsequence

  sequence s_bts_pending;
    bts_pend_reg;
  endsequence

  a_bts_after_rec: assert property (@(posedge clk) disable iff (rst)
    s_store_end and s_bts_pending |=> branch_trace_go && !seq_busy)
    else $error("branch trace started before record completed");

  a_irq_held: assert property (@(posedge clk) disable iff (rst)
    (state_reg == PSC_BTS) || (state_reg == PSC_STORE) || (state_reg == PSC_NEXT)
    |=> !overflow_interrupt_request)
    else $error("interrupt raised while capture unfinished");

  a_arm_on_ovf: assert property (@(posedge clk) disable iff (rst)
    (state_reg == PSC_IDLE) && ctr_ovf && smp_on && !plain_irq_reg |=> state_reg == PSC_ARMED)
    else $error("overflow did not arm capture");

  a_only_listed: assert property (@(posedge clk) disable iff (rst)
    (state_reg == PSC_ARMED) && smp_on && evt_valid
    && !psc_is_precise(evt_select, evt_qual) |=> state_reg == PSC_ARMED)
    else $error("unlisted event left armed state");

  a_cap_fields: assert property (@(posedge clk) disable iff (rst)
    capability[PSC_BIT_SAVE_ARCH] && (capability[PSC_BIT_LAYOUT_HI:PSC_BIT_LAYOUT_LO] == 4'h0))
    else $error("capability layout fields wrong");

  a_freeze_stop: assert property (@(posedge clk) disable iff (rst)
    irq_fire && debug_ctrl_reg[PSC_BIT_FREEZE] |=> glob_enable_reg == PSC_ZERO64)
    else $error("counters not frozen on interrupt");

  a_skip_full: assert property (@(posedge clk) disable iff (rst)
    trigger && !bounds_ok |=> (state_reg == PSC_IDLE) && !seq_start_reg
    && glob_status_reg[PSC_BIT_BUF_FULL])
    else $error("capture not skipped on bounds failure");

  a_irq_after_rec: assert property (@(posedge clk) disable iff (rst)
    s_store_end ##0 !bts_pend_reg |=> ##1 overflow_interrupt_request)
    else $error("interrupt not issued after last entry");

  a_gate_count: assert property (@(posedge clk) disable iff (rst)
    !glob_enable_reg[PSC_BIT_CTR0] && !wr_ctr && !store_ok |=> $stable(counter_reg))
    else $error("counter moved while globally disabled");

  a_status_set: assert property (@(posedge clk) disable iff (rst)
    ctr_ovf |=> glob_status_reg[PSC_BIT_CTR0])
    else $error("overflow not recorded in status");

endmodule
`default_nettype wire

//--- tb/psc_mem_model.sv
`timescale 1ns/1ns
`default_nettype none
module psc_mem_model
(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        slow,
  input  wire logic        st_valid,
  input  wire logic [63:0] st_addr,
  input  wire logic [63:0] st_data,
  output logic             st_ready
);
  logic [63:0] addr_q[$];
  logic [63:0] data_q[$];
  logic [1:0]  wait_cnt;

  // slow mode holds ready low three cycles out of four
  always_ff @(posedge clk)
  begin
    if (rst)
      wait_cnt <= 2'h0;
    else
      wait_cnt <= wait_cnt + 2'h1;
  end

  assign st_ready = !rst && (!slow || wait_cnt == 2'h3);

  // one whole 64-bit entry per accepted handshake
  always @(posedge clk)
  begin
    if (!rst && st_valid && st_ready)
    begin
      addr_q.push_back(st_addr);
      data_q.push_back(st_data);
    end
  end
endmodule
`default_nettype wire

//--- tb/tb_precise_event_sampling_ctrl.sv
`timescale 1ns/1ns
`default_nettype none
module tb_precise_event_sampling_ctrl;
  import psc_pkg::*;
  logic clk, rst, msr_wr, msr_rd, msr_rd_valid, evt_valid, evt_ring0, insn_retire;
  logic branch_trace_req, branch_trace_go, branch_trace_done, overflow_interrupt_request;
  logic st_valid, st_ready, slow;
  logic [11:0]  msr_addr;
  logic [63:0]  msr_wdata, msr_rdata, core_flags, core_ip, st_addr, st_data, rv;
  logic [7:0]   evt_select, evt_qual;
  logic [511:0] core_gprs;
  int           n_errors, compares, irq_cnt, irq_at, go_at;

  psc_ctrl i_dut (.clk(clk), .rst(rst), .msr_wr(msr_wr), .msr_rd(msr_rd),
    .msr_addr(msr_addr), .msr_wdata(msr_wdata), .msr_rdata(msr_rdata),
    .msr_rd_valid(msr_rd_valid), .evt_valid(evt_valid), .evt_select(evt_select),
    .evt_qual(evt_qual), .evt_ring0(evt_ring0), .insn_retire(insn_retire),
    .core_flags(core_flags), .core_ip(core_ip), .core_gprs(core_gprs),
    .branch_trace_req(branch_trace_req), .branch_trace_go(branch_trace_go),
    .branch_trace_done(branch_trace_done),
    .overflow_interrupt_request(overflow_interrupt_request),
    .st_valid(st_valid), .st_addr(st_addr), .st_data(st_data), .st_ready(st_ready));
  psc_mem_model i_mem (.clk(clk), .rst(rst), .slow(slow), .st_valid(st_valid),
    .st_addr(st_addr), .st_data(st_data), .st_ready(st_ready));

  //////////////////////////////////////////////////////////////////////////////
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // note how many entries had landed when each request or go pulse appeared
  always @(posedge clk)
  begin
    if (overflow_interrupt_request === 1'b1)
    begin
      irq_cnt++;
      irq_at = i_mem.addr_q.size();
    end
    if (branch_trace_go === 1'b1)
      go_at = i_mem.addr_q.size();
  end

  //////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    compares++;
    if (got !== exp)
    begin
      n_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [63:0] d);
    @(negedge clk);
    msr_wr = 1'b1;
    msr_addr = a;
    msr_wdata = d;
    @(negedge clk);
    msr_wr = 1'b0;
  endtask

  task automatic rd(input logic [11:0] a);
    @(negedge clk);
    msr_rd = 1'b1;
    msr_addr = a;
    @(negedge clk);
    msr_rd = 1'b0;
    chk({63'h0, msr_rd_valid}, 64'h1);
    rv = msr_rdata;
  endtask

  task automatic evt(input logic [7:0] code, input logic [7:0] qual);
    @(negedge clk);
    evt_valid = 1'b1;
    evt_select = code;
    evt_qual = qual;
    @(negedge clk);
    evt_valid = 1'b0;
    @(negedge clk);
  endtask

  // the retiring instruction carries fresh state; it is wiped right after
  task automatic retire();
    @(negedge clk);
    insn_retire = 1'b1;
    core_flags = 64'h0000_0000_0000_0246;
    core_ip = 64'h0000_0000_0040_1000;
    for (int j = 0; j < 8; j++)
      core_gprs[j*64 +: 64] = 64'hA5A5_0000_0000_0000 | 64'(j);
    @(negedge clk);
    insn_retire = 1'b0;
    core_flags = 64'h0;
    core_ip = 64'h0;
    core_gprs = '0;
  endtask

  task automatic setup(input logic [7:0] code, input logic [63:0] maxv, input logic fr,
                       input logic smp);
    i_mem.addr_q.delete();
    i_mem.data_q.delete();
    wr(PSC_ADR_GLOB_ENABLE, 64'h0);
    wr(PSC_ADR_SAMPLE_ENABLE, 64'h0);
    repeat (4) @(negedge clk);
    wr(PSC_ADR_GLOB_OVF_CLR, 64'h4000_0000_0000_0001);
    wr(PSC_ADR_COUNTER0, 64'h0000_00FF_FFFF_FFFF);
    wr(PSC_ADR_CTR_RELOAD, 64'h10);
    wr(PSC_ADR_BUF_BASE, 64'h1000);
    wr(PSC_ADR_BUF_INDEX, 64'h0);
    wr(PSC_ADR_BUF_MAX, maxv);
    wr(PSC_ADR_DEBUG_CTRL, {63'h0, fr});
    wr(PSC_ADR_EVSEL0, 64'h0041_0000 | {48'h0, 8'h00, code});
    wr(PSC_ADR_SAMPLE_ENABLE, {63'h0, smp});
    wr(PSC_ADR_GLOB_ENABLE, 64'h1);
  endtask

  task automatic wait_irq(input int target);
    int k;
    k = 0;
    while (irq_cnt < target && k < 400)
    begin
      @(negedge clk);
      k++;
    end
    chk(64'(irq_cnt), 64'(target));
  endtask

  //////////////////////////////////////////////////////////////////////////////
  task automatic sc_capture(input logic sl, input logic branch_trace_store, input logic fr);
    int n0;
    logic [63:0] e;
    n0 = irq_cnt;
    slow = sl;
    setup(8'hC5, 64'h1000, fr, 1'b1);
    evt(8'hC5, 8'h00);
    evt(8'hC5, 8'h00);
    if (branch_trace_store)
    begin
      @(negedge clk);
      branch_trace_req = 1'b1;
      @(negedge clk);
      branch_trace_req = 1'b0;
    end
    retire();
    if (branch_trace_store)
    begin
      for (int k = 0; k < 400 && go_at < 0; k++)
        @(negedge clk);
      chk(64'(go_at), 64'd10);
      repeat (6) @(negedge clk);
      chk(64'(irq_cnt), 64'(n0));
      branch_trace_done = 1'b1;
      @(negedge clk);
      branch_trace_done = 1'b0;
    end
    wait_irq(n0 + 1);
    chk(64'(irq_at), 64'd10);
    chk(64'(i_mem.addr_q.size()), 64'd10);
    for (int k = 0; k < 10; k++)
    begin
      e = (k == 0) ? 64'h246 : (k == 1) ? 64'h40_1000 : 64'hA5A5_0000_0000_0000 | 64'(k - 2);
      chk(i_mem.addr_q[k], 64'h1000 + 64'(8 * k));
      chk(i_mem.data_q[k], e);
    end
    rd(PSC_ADR_GLOB_STATUS);
    chk(rv, 64'h0);
    rd(PSC_ADR_COUNTER0);
    chk(rv, 64'h10);
    rd(PSC_ADR_BUF_INDEX);
    chk(rv, 64'h50);
    rd(PSC_ADR_GLOB_ENABLE);
    chk(rv, {63'h0, !fr});
    go_at = -1;
  endtask

  // no capture: unlisted code, sampling off, or buffer bound too small
  task automatic sc_skip(input logic [7:0] code, input logic [63:0] maxv, input logic smp,
                         input logic [63:0] st_exp);
    int n0;
    n0 = irq_cnt;
    setup(code, maxv, 1'b0, smp);
    evt(code, 8'h00);
    evt(code, 8'h00);
    retire();
    repeat (30) @(negedge clk);
    chk(64'(i_mem.addr_q.size()), 64'h0);
    chk(64'(irq_cnt), 64'(n0));
    rd(PSC_ADR_GLOB_STATUS);
    chk(rv, st_exp);
    wr(PSC_ADR_GLOB_OVF_CLR, 64'h4000_0000_0000_0001);
    rd(PSC_ADR_GLOB_STATUS);
    chk(rv, 64'h0);
  endtask

  task automatic sc_gating();
    setup(8'hC5, 64'h1000, 1'b0, 1'b0);
    wr(PSC_ADR_GLOB_ENABLE, 64'h0);
    evt(8'hC5, 8'h00);
    rd(PSC_ADR_COUNTER0);
    chk(rv, 64'h0000_00FF_FFFF_FFFF);
    rd(PSC_ADR_CAPABILITY);
    chk(rv, 64'h0000_0000_0000_00C0);
    rd(12'h123);
    chk(rv, 64'h0);
  endtask

  //////////////////////////////////////////////////////////////////////////////
  task automatic give_verdict();
    $display("errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  initial
  begin
    {rst, msr_wr, msr_rd, evt_valid, evt_ring0, insn_retire} = 6'b100000;
    {branch_trace_req, branch_trace_done, slow} = 3'b000;
    {msr_addr, msr_wdata, evt_select, evt_qual} = '0;
    {core_flags, core_ip, core_gprs} = '0;
    {n_errors, compares, irq_cnt, irq_at, go_at} = {32'd0, 32'd0, 32'd0, 32'd0, -32'sd1};
    repeat (20) @(negedge clk);
    rst = 1'b0;
    sc_gating();
    sc_capture(1'b0, 1'b0, 1'b0);
    sc_capture(1'b1, 1'b1, 1'b1);
    sc_skip(8'hC5, 64'h40, 1'b1, 64'h4000_0000_0000_0001);
    sc_skip(8'hC5, 64'h1000, 1'b0, 64'h1);
    sc_skip(8'h3C, 64'h1000, 1'b1, 64'h1);
    give_verdict();
  end

  initial
  begin
    #200000;
    n_errors++;
    give_verdict();
  end
endmodule
`default_nettype wire
